// >>> src/ctw_wake.sv
`timescale 1ns/100ps
module ctw_wake #(
  parameter int FILTER_CYC = ctw_pkg::WAKE_FILTER_CYC,
  parameter int TIMEOUT_CYC = ctw_pkg::WAKE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic standby_select,
  input wire logic tx_data,
  input wire logic bus_dominant,
  output logic rx_data,
  output logic drive_dominant,
  output logic driver_enable,
  output logic main_rx_enable,
  output logic monitor_enable,
  output logic bus_bias_ground,
  output ctw_pkg::ctw_state_t wake_state
);
  import ctw_pkg::*;

  logic rst_s1, rst_s2;
  logic stb_s1, stb_s2, tx_s1, tx_s2, bus_s1, bus_s2, bus_d;
  logic [CNT_W-1:0] phase_cnt, tmo_cnt;
  logic filtered, timeout, standby;
  ctw_state_t state, next_state;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Pins are asynchronous to clk; reset state is standby like the pin pull-up
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      stb_s1 <= 1'b1;
      stb_s2 <= 1'b1;
    end else begin
      stb_s1 <= standby_select;
      stb_s2 <= stb_s1;
    end
  end

  // Transmit idles recessive, matching its pull-up
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      tx_s1 <= 1'b1;
      tx_s2 <= 1'b1;
    end else begin
      tx_s1 <= tx_data;
      tx_s2 <= tx_s1;
    end
  end

  // Bus starts recessive so reset gives no false edge
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      bus_s1 <= 1'b0;
      bus_s2 <= 1'b0;
      bus_d <= 1'b0;
    end else begin
      bus_s1 <= bus_dominant;
      bus_s2 <= bus_s1;
      bus_d <= bus_s2;
    end
  end

  assign standby = stb_s2;

  // Phase length counter, saturating; restarts on every bus edge
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      phase_cnt <= '0;
    end else if (!standby || bus_s2 != bus_d) begin
      phase_cnt <= '0;
    end else if (phase_cnt != {CNT_W{1'b1}}) begin
      phase_cnt <= phase_cnt + 1'b1;
    end
  end

  // Single threshold sits between min and max filter limits
  assign filtered = phase_cnt == CNT_W'(FILTER_CYC);

  // Timeout counts from first filtered dominant until recognition; cleared in idle and woken
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      tmo_cnt <= '0;
    end else if (state == ctw_idle || state == ctw_woken || !standby) begin
      tmo_cnt <= '0;
    end else if (tmo_cnt != {CNT_W{1'b1}}) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end
  assign timeout = tmo_cnt >= CNT_W'(TIMEOUT_CYC);

  always_comb begin
    next_state = state;
    case (state)
      ctw_idle: begin
        if (filtered && bus_s2) begin
          next_state = ctw_dom1;
        end
      end
      ctw_dom1: begin
        if (filtered && !bus_s2) begin
          next_state = ctw_rec1;
        end
      end
      ctw_rec1: begin
        if (filtered && bus_s2) begin
          next_state = ctw_dom2;
        end
      end
      ctw_dom2: begin
        if (filtered && !bus_s2) begin
          next_state = ctw_woken;
        end
      end
      ctw_woken: next_state = ctw_woken;
      default: next_state = ctw_idle;
    endcase
    if (state != ctw_idle && state != ctw_woken && timeout) begin
      next_state = ctw_idle;
    end
    if (!standby) begin
      next_state = ctw_idle;
    end
  end

  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= ctw_idle;
    end else begin
      state <= next_state;
    end
  end

  // Wake output latches low on a filtered dominant after recognition
  logic wake_low;
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      wake_low <= 1'b0;
    end else if (!standby) begin
      wake_low <= 1'b0;
    end else if (state == ctw_woken && filtered && bus_s2) begin
      wake_low <= 1'b1;
    end
  end

  // Standby ignores the bus level on rx_data
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      rx_data <= 1'b1;
    end else begin
      rx_data <= standby ? !wake_low : !bus_s2;
    end
  end

  // Transmit is ignored in standby
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      drive_dominant <= 1'b0;
      driver_enable <= 1'b0;
    end else begin
      drive_dominant <= !standby && !tx_s2;
      driver_enable <= !standby;
    end
  end

  // Main receiver and monitor swap over with the mode
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      main_rx_enable <= 1'b0;
      monitor_enable <= 1'b1;
      bus_bias_ground <= 1'b1;
    end else begin
      main_rx_enable <= !standby;
      monitor_enable <= standby;
      bus_bias_ground <= standby;
    end
  end

  assign wake_state = state;

  a_standby_drive: assert property (@(posedge clk) disable iff (!rst_s2)
    standby |=> !drive_dominant && !driver_enable)
    else $error("driver active in standby");
  a_rx_high_pre: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && state != ctw_woken && !wake_low |=> rx_data)
    else $error("rx low before wake");
  a_rx_stays_low: assert property (@(posedge clk) disable iff (!rst_s2)
    wake_low && standby ##1 standby |-> wake_low)
    else $error("wake low released in standby");
  a_wake_order: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_woken && $past(state) != ctw_woken |-> $past(state) == ctw_dom2)
    else $error("wake skipped a phase");
  a_short_ignored: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_idle && phase_cnt < CNT_W'(FILTER_CYC) |=> state == ctw_idle)
    else $error("short phase counted");
  a_timeout_reset: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && timeout && state inside {ctw_dom1, ctw_rec1, ctw_dom2} |=> state == ctw_idle)
    else $error("timeout ignored");
  a_exit_clears: assert property (@(posedge clk) disable iff (!rst_s2)
    !standby |=> state == ctw_idle && !wake_low)
    else $error("exit did not clear");
  a_normal_mirror: assert property (@(posedge clk) disable iff (!rst_s2)
    !standby |=> rx_data == !$past(bus_s2) && drive_dominant == !$past(tx_s2))
    else $error("normal mode path wrong");
  a_long_counts: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && state == ctw_idle && filtered && bus_s2 && stb_s1 |=> state == ctw_dom1)
    else $error("long dominant missed");

  // Mode and per-state checks; these catch a skipped phase or one taken without a filtered level
  a_mon_standby: assert property (@(posedge clk) disable iff (!rst_s2)
    standby |=> monitor_enable && bus_bias_ground)
    else $error("monitor off in standby");

  a_rx_off_standby: assert property (@(posedge clk) disable iff (!rst_s2)
    standby |=> !main_rx_enable)
    else $error("main receiver on in standby");

  a_normal_enables: assert property (@(posedge clk) disable iff (!rst_s2)
    !standby |=> driver_enable && main_rx_enable && !monitor_enable && !bus_bias_ground)
    else $error("normal mode enables wrong");

  a_dom1_entry: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_dom1 && $past(state) != ctw_dom1 |-> $past(state) == ctw_idle)
    else $error("first dominant entered wrongly");

  a_rec1_entry: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_rec1 && $past(state) != ctw_rec1 |-> $past(state) == ctw_dom1)
    else $error("first recessive entered wrongly");

  a_dom2_entry: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_dom2 && $past(state) != ctw_dom2 |-> $past(state) == ctw_rec1)
    else $error("second dominant entered wrongly");

  a_hold_unfiltered: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && !filtered && !timeout && state inside {ctw_dom1, ctw_rec1, ctw_dom2}
    |=> state == $past(state))
    else $error("pattern moved without filtered phase");

  a_woken_holds: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && state == ctw_woken |=> state == ctw_woken)
    else $error("woken state lost in standby");

  a_wake_needs_woken: assert property (@(posedge clk) disable iff (!rst_s2)
    $rose(wake_low) |-> $past(state) == ctw_woken)
    else $error("wake shown before recognition");

  a_wake_on_dom: assert property (@(posedge clk) disable iff (!rst_s2)
    $rose(wake_low) |-> $past(bus_s2))
    else $error("wake shown on recessive");

  a_rx_follows_wake: assert property (@(posedge clk) disable iff (!rst_s2)
    standby |=> rx_data == !$past(wake_low))
    else $error("rx not tied to wake in standby");

  a_phase_restart: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && bus_s2 != bus_d |=> phase_cnt == '0)
    else $error("phase count not restarted");

  a_wake_low_stby: assert property (@(posedge clk) disable iff (!rst_s2)
    wake_low |-> $past(standby))
    else $error("wake low outside standby");

  a_dom1_level: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_dom1 && $past(state) == ctw_idle |-> $past(bus_s2))
    else $error("first phase not dominant");

  a_rec2_level: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_woken && $past(state) == ctw_dom2 |-> !$past(bus_s2))
    else $error("last phase not recessive");

  a_standby_sync: assert property (@(posedge clk) disable iff (!rst_s2)
    standby == $past(stb_s1))
    else $error("mode select not synchronised");

  a_tmo_cleared: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_idle |=> tmo_cnt == '0)
    else $error("timeout count kept in idle");

  a_tmo_start: assert property (@(posedge clk) disable iff (!rst_s2)
    state == ctw_dom1 && $past(state) == ctw_idle |-> tmo_cnt == '0)
    else $error("timeout not started fresh");

  a_normal_tx_idle: assert property (@(posedge clk) disable iff (!rst_s2)
    !standby && tx_s2 |=> !drive_dominant)
    else $error("driver dominant with transmit high");

  a_rx_zero_after: assert property (@(posedge clk) disable iff (!rst_s2)
    standby && wake_low |=> !rx_data)
    else $error("rx high after wake");

  c_wake: cover property (@(posedge clk) disable iff (!rst_s2) $rose(wake_low));
  c_woken: cover property (@(posedge clk) disable iff (!rst_s2) state == ctw_woken);
  c_exit: cover property (@(posedge clk) disable iff (!rst_s2) $fell(standby));
  c_timeout: cover property (@(posedge clk) disable iff (!rst_s2)
    timeout && state == ctw_rec1);
  c_normal_tx: cover property (@(posedge clk) disable iff (!rst_s2) $rose(drive_dominant));
endmodule

// >>> src/ctw_pkg.sv
package ctw_pkg;
  localparam int CLK_MHZ = 250;
  localparam int WAKE_FILTER_NS = 1000;
  localparam int WAKE_TIMEOUT_US = 1000;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W = 24;
  typedef enum logic [2:0] {
    ctw_idle, ctw_dom1, ctw_rec1, ctw_dom2, ctw_rec2, ctw_woken
  } ctw_state_t;
endpackage

// >>> testbench/ctw_host.sv
`timescale 1ns/100ps
module ctw_host (
  input wire logic clk,
  input wire logic rx_data,
  input wire logic sleep_req,
  input wire logic wake_en,
  input wire logic send_dom,
  output logic standby_select,
  output logic tx_data
);
  logic rx_q = 1'b1;
  logic woke = 1'b0;
  initial standby_select = 1'b1;
  initial tx_data = 1'b1;
  // Pins change on the falling edge, well clear of the device's sampling
  always @(negedge clk) begin
    rx_q <= rx_data;
    tx_data <= !send_dom;
    if (!sleep_req) begin
      woke <= 1'b0;
    end else if (wake_en && standby_select && rx_q && !rx_data) begin
      woke <= 1'b1;
    end
    standby_select <= sleep_req && !woke;
  end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ctw_pkg::*;
  logic clk = 0, nrst = 0, sleep_req = 1, wake_en = 0, send_dom = 0, bus = 0, smp = 0, d, t;
  logic standby_select, tx_data, rx_data, drive_dominant, driver_enable, main_rx_enable;
  logic monitor_enable, bus_bias_ground;
  ctw_state_t wake_state;
  logic [3:0] exp_q[$];
  int mismatches = 0, tests_run = 0, cyc = 0;
  ctw_wake #(.FILTER_CYC(8), .TIMEOUT_CYC(200)) u_ctw_wake (.clk(clk), .nrst(nrst),
    .standby_select(standby_select), .tx_data(tx_data), .bus_dominant(bus),
    .rx_data(rx_data), .drive_dominant(drive_dominant), .driver_enable(driver_enable),
    .main_rx_enable(main_rx_enable), .monitor_enable(monitor_enable),
    .bus_bias_ground(bus_bias_ground), .wake_state(wake_state));
  ctw_host u_ctw_host (.clk(clk), .rx_data(rx_data), .sleep_req(sleep_req),
    .wake_en(wake_en), .send_dom(send_dom), .standby_select(standby_select),
    .tx_data(tx_data));
  initial forever #2 clk = ~clk;
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Run is about 700 cycles; ceiling leaves room for slow phases
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  // Result order: rx_data, drive_dominant, driver_enable, monitor_enable
  task chk(input logic [3:0] e);
    tests_run++;
    if ({rx_data, drive_dominant, driver_enable, monitor_enable} !== e) begin
      mismatches++;
      $display("[ERR] %0t outputs %b expected %b", $time,
        {rx_data, drive_dominant, driver_enable, monitor_enable}, e);
    end
  endtask
  // Look just after the edge so registered outputs have settled
  always @(posedge clk) begin
    if (smp) begin
      #1 chk(exp_q.pop_front());
    end
  end
  task automatic ph(input logic v, input int n);
    bus = v;
    repeat (n) @(negedge clk);
  endtask
  task automatic nt(input logic [3:0] e);
    exp_q.push_back(e);
    smp = 1;
    @(negedge clk) smp = 0;
  endtask
  initial begin
    void'($urandom(32'h8B3A));
    repeat (20) @(negedge clk);
    nrst = 1;
    repeat (6) @(negedge clk);
    // Bursts shorter than the filter must leave the detector idle
    repeat (12) begin
      ph(1'b1, 1 + int'($urandom % 5));
      ph(1'b0, 1 + int'($urandom % 5));
    end
    nt(4'b1001);
    ph(1, 20); ph(0, 20); ph(1, 20); ph(0, 20);
    nt(4'b1001);
    ph(1, 20);
    nt(4'b0001);
    ph(0, 20);
    nt(4'b0001);
    sleep_req = 0;
    ph(0, 10);
    nt(4'b1010);
    repeat (10) begin
      {d, t} = 2'($urandom);
      bus = d;
      send_dom = t;
      repeat (6) @(negedge clk);
      nt({!d, t, 2'b10});
    end
    sleep_req = 1;
    send_dom = 1;
    ph(1, 20);
    nt(4'b1001);
    // Pattern started above stalls in a long recessive and times out;
    // a fresh full pattern then only reaches recognition, no dominant yet
    ph(0, 200); ph(1, 20); ph(0, 20); ph(1, 20); ph(0, 20);
    nt(4'b1001);
    ph(0, 20);
    wake_en = 1;
    ph(1, 20);
    nt(4'b0110);
    ph(0, 10);
    nt(4'b1110);
    sleep_req = 0;
    ph(0, 6);
    sleep_req = 1;
    wake_en = 0;
    ph(1, 20);
    nt(4'b1001);
    stop_test();
  end
endmodule
